// ### fieldbus_slave_io_connections.sv
// Purpose: Slave side of the predefined master/slave I/O connections
// Assumes: Frames arrive decoded from a CAN controller on the same clock
// Notes: Registers reached over APB; node address strap is synchronised
// How it works
// - Trigger writes accept only 82 or 83 hex
// - Bit-strobe produced size never above eight
// - Sizes writable configuring; identifiers, profile read-only
// - Strobe command carries 64 bits, one per node
// - Strobe commands ignored until connection allocated
// - Empty strobe is idle, else run event
// - Strobe response returns at most eight bytes
// - One class 2/3 server receives and answers strobe
// - Poll command carries up to 65535 bytes
// - Poll commands ignored until connection allocated
// - Empty poll is idle, else run event
// - Poll response returns up to 65535 bytes
// - Instance 2 inbound data, instance 4 outbound
// - Instance 4 consumes into ack handler one
// - Cyclic-only allocation creates instance 4, and instance 2 when HAS_OUTPUT is set
// - Poll-only allocation: instance 2 consumes output
// - Poll with cyclic: instance 2 stays poll
// - Ack suppression makes class 0 producers
module fieldbus_slave_io_connections #(
  parameter int NODE_W = 6,
  parameter bit HAS_OUTPUT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NODE_W-1:0] nodeAddrPin,
  input wire fieldbus_io_pkg::rxFrame_t rxIn,
  output fieldbus_io_pkg::txReq_t txOut,
  output fieldbus_io_pkg::appEvt_t appEvt,
  output logic [fieldbus_io_pkg::DATA_W-1:0] outData
);
  import fieldbus_io_pkg::*;

  if (NODE_W < 1 || NODE_W > 6)
  begin : g_bad_width
    $error("NODE_W must lie between 1 and 6");
  end

  logic rstMeta;
  logic rstSync;
  logic preadyReg;
  logic pslverrReg;
  logic [31:0] prdataReg;
  logic [7:0] allocReg;
  logic [1:0] selReg;
  logic [NODE_W-1:0] addrS1;
  logic [NODE_W-1:0] addrS2;
  logic [NODE_W-1:0] addrS3;
  logic [NODE_W-1:0] macIdReg;
  connState_t stateReg [3];
  logic [7:0] trigReg [3];
  logic [15:0] psizeReg [3];
  logic [15:0] csizeReg [3];
  logic [7:0] defTrig [3];
  logic [15:0] defP [3];
  logic [15:0] defC [3];
  logic [2:0] existVec;
  inst2Mode_t inst2Mode;
  logic ackSup;
  logic cyclicReq;
  logic accessNew;
  logic wrOk;
  logic selOk;
  logic [1:0] cIdx;
  logic [31:0] rdData;
  logic errCalc;
  txReq_t txReg;
  appEvt_t evtReg;
  logic [DATA_W-1:0] outDataReg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync);

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Node address strap, accepted per bit when stages agree
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      addrS1 <= '0;
      addrS2 <= '0;
      addrS3 <= '0;
      macIdReg <= '0;
    end
    else if (clkEn)
    begin
      addrS1 <= nodeAddrPin;
      addrS2 <= addrS1;
      addrS3 <= addrS2;
      macIdReg <= (addrS2 & addrS3) | (macIdReg & (addrS2 ^ addrS3));
    end
  end

  // Allocation decode
  always_comb
  begin
    ackSup = allocReg[ALLOC_ACKSUP];
    cyclicReq = allocReg[ALLOC_COS] | allocReg[ALLOC_CYC];
    existVec[0] = allocReg[ALLOC_POLL] | (HAS_OUTPUT & cyclicReq);
    existVec[1] = allocReg[ALLOC_STROBE];
    existVec[2] = cyclicReq;
    if (allocReg[ALLOC_POLL])
      inst2Mode = MODE_POLL;
    else if (cyclicReq && ackSup)
      inst2Mode = MODE_COS_UNACK;
    else if (cyclicReq)
      inst2Mode = MODE_COS_ACK;
    else
      inst2Mode = MODE_NONE;
    defTrig[0] = (inst2Mode == MODE_COS_UNACK) ? TRIG_CLASS0 :
      (inst2Mode == MODE_COS_ACK) ? TRIG_CLASS3 : TRIG_CLASS2;
    defP[0] = (inst2Mode == MODE_POLL) ? DEF_IO_SIZE : ZERO_SIZE;
    defC[0] = DEF_IO_SIZE;
    defTrig[1] = TRIG_CLASS2;
    defP[1] = STROBE_MAX;
    defC[1] = STROBE_MAX;
    defTrig[2] = ackSup ? TRIG_CLASS0 : TRIG_CLASS3;
    defP[2] = DEF_IO_SIZE;
    defC[2] = ZERO_SIZE;
  end

  assign accessNew = psel & penable & ~preadyReg;
  assign wrOk = psel & penable & preadyReg & pwrite & ~pslverrReg;
  assign selOk = (selReg != 2'h3);
  assign cIdx = selOk ? selReg : 2'h0;

  // Read data and refusal decode
  always_comb
  begin
    rdData = '0;
    errCalc = 1'b0;
    case (paddr)
      REG_ALLOC:
        rdData = {24'h0, allocReg};
      REG_RELEASE, REG_CMD:
        rdData = '0;
      REG_SEL:
        rdData = {30'h0, selReg};
      REG_TRIG:
      begin
        rdData = {24'h0, trigReg[cIdx]};
        errCalc = !selOk || (pwrite && (stateReg[cIdx] != ST_CONFIG ||
          (pwdata[7:0] != TRIG_CLASS2 && pwdata[7:0] != TRIG_CLASS3)));
      end
      REG_PSIZE:
      begin
        rdData = {16'h0, psizeReg[cIdx]};
        errCalc = !selOk || (pwrite && (stateReg[cIdx] != ST_CONFIG ||
          (cIdx == CONN_STROBE && pwdata[15:0] > STROBE_MAX)));
      end
      REG_CSIZE:
      begin
        rdData = {16'h0, csizeReg[cIdx]};
        errCalc = !selOk || (pwrite && stateReg[cIdx] != ST_CONFIG);
      end
      REG_OUTID:
      begin
        rdData = {21'h0, 2'h1, cIdx, 1'b0, 6'(macIdReg)};
        errCalc = !selOk || pwrite;
      end
      REG_INID:
      begin
        rdData = {21'h0, 2'h2, 6'(macIdReg), 1'b1, cIdx};
        errCalc = !selOk || pwrite;
      end
      REG_PROFILE:
      begin
        rdData = {24'h0, PROFILE_VAL};
        errCalc = !selOk || pwrite;
      end
      REG_STATE:
      begin
        rdData = {24'h0, inst2Mode, stateReg[2], stateReg[1], stateReg[0]};
        errCalc = pwrite;
      end
      REG_PATH:
      begin
        rdData = {16'h0, ACK_HANDLER_CLASS, ACK_HANDLER_INST};
        errCalc = pwrite;
      end
      default:
        errCalc = 1'b1;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg <= '0;
    end
    else if (clkEn)
    begin
      if (accessNew)
      begin
        preadyReg <= 1'b1;
        pslverrReg <= errCalc;
        prdataReg <= errCalc ? 32'h0 : rdData;
      end
      else
      begin
        preadyReg <= 1'b0;
        pslverrReg <= 1'b0;
      end
    end
  end

  // Allocation bits and attribute selector
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      allocReg <= '0;
      selReg <= '0;
    end
    else if (clkEn && wrOk)
    begin
      if (paddr == REG_ALLOC)
        allocReg <= allocReg | pwdata[7:0];
      if (paddr == REG_RELEASE)
        allocReg <= allocReg & ~pwdata[7:0];
      if (paddr == REG_SEL)
        selReg <= pwdata[1:0];
    end
  end

  // Per-connection state and attributes
  for (genvar k = 0; k < 3; k++)
  begin : g_conn
    always_ff @(posedge clk or negedge rstSync)
    begin
      if (!rstSync)
      begin
        stateReg[k] <= ST_NONEX;
        trigReg[k] <= '0;
        psizeReg[k] <= '0;
        csizeReg[k] <= '0;
      end
      else if (clkEn)
      begin
        if (!existVec[k])
          stateReg[k] <= ST_NONEX;
        else if (stateReg[k] == ST_NONEX)
        begin
          stateReg[k] <= ST_CONFIG;
          trigReg[k] <= defTrig[k];
          psizeReg[k] <= defP[k];
          csizeReg[k] <= defC[k];
        end
        else
        begin
          if (wrOk && cIdx == 2'(k))
          begin
            if (paddr == REG_TRIG)
              trigReg[k] <= pwdata[7:0];
            if (paddr == REG_PSIZE)
              psizeReg[k] <= pwdata[15:0];
            if (paddr == REG_CSIZE)
              csizeReg[k] <= pwdata[15:0];
          end
          if (wrOk && paddr == REG_CMD)
          begin
            if (pwdata[CMD_APPLY+k] && stateReg[k] == ST_CONFIG)
              stateReg[k] <= ST_ESTAB;
            if (pwdata[CMD_TMO+k] && stateReg[k] == ST_ESTAB)
              stateReg[k] <= ST_TIMEOUT;
          end
        end
      end
    end

    a_trig_legal: assert property (
      clkEn && stateReg[k] == ST_CONFIG && wrOk && cIdx == 2'(k) &&
      paddr == REG_TRIG |=> trigReg[k] == TRIG_CLASS2 ||
      trigReg[k] == TRIG_CLASS3)
    else $error("trigger took an illegal value");
  end

  // Received commands, events and response requests
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      evtReg <= '0;
      txReg <= '0;
      outDataReg <= '0;
    end
    else if (clkEn)
    begin
      evtReg.idle <= 1'b0;
      evtReg.run <= 1'b0;
      evtReg.trigger <= 1'b0;
      evtReg.ackSeen <= 1'b0;
      txReg.valid <= 1'b0;
      if (rxIn.valid)
      begin
        case (rxIn.target)
          CONN_STROBE:
            if (stateReg[1] != ST_NONEX)
            begin
              evtReg.idle <= (rxIn.len == 4'h0);
              evtReg.run <= (rxIn.len != 4'h0);
              evtReg.trigger <= 1'b1;
              evtReg.strobeBit <= rxIn.data[macIdReg];
              txReg <= '{valid: 1'b1, conn: CONN_STROBE, len: psizeReg[1]};
            end
          CONN_INST2:
            if (stateReg[0] != ST_NONEX && inst2Mode != MODE_NONE)
            begin
              evtReg.idle <= (rxIn.len == 4'h0);
              evtReg.run <= (rxIn.len != 4'h0);
              evtReg.trigger <= 1'b1;
              outDataReg <= rxIn.data;
              if (inst2Mode != MODE_COS_UNACK)
                txReg <= '{valid: 1'b1, conn: CONN_INST2, len: psizeReg[0]};
            end
          CONN_INST4:
            if (stateReg[2] != ST_NONEX && !ackSup)
              evtReg.ackSeen <= 1'b1;
          default:
            evtReg.trigger <= 1'b0;
        endcase
      end
    end
  end

  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign prdata = prdataReg;
  assign txOut = txReg;
  assign appEvt = evtReg;
  assign outData = outDataReg;

  a_strobe_size: assert property (
    stateReg[1] != ST_NONEX |-> psizeReg[1] <= STROBE_MAX)
  else $error("strobe produced size above eight");

  a_ro_refused: assert property (
    clkEn && accessNew && pwrite &&
    (paddr == REG_OUTID || paddr == REG_INID || paddr == REG_PROFILE)
    |=> preadyReg && pslverrReg)
  else $error("read-only attribute write not refused");

  a_strobe_ignored: assert property (
    clkEn && rxIn.valid && rxIn.target == CONN_STROBE &&
    stateReg[1] == ST_NONEX |=> !evtReg.run && !evtReg.idle && !txReg.valid)
  else $error("strobe acted on before allocation");

  a_strobe_idle: assert property (
    clkEn && rxIn.valid && rxIn.target == CONN_STROBE &&
    stateReg[1] != ST_NONEX |=> evtReg.idle == ($past(rxIn.len) == 4'h0)
    && evtReg.run != evtReg.idle)
  else $error("strobe idle or run event wrong");

  a_strobe_resp: assert property (
    txReg.valid && txReg.conn == CONN_STROBE |-> txReg.len <= STROBE_MAX)
  else $error("strobe response longer than eight bytes");

  a_poll_ignored: assert property (
    clkEn && rxIn.valid && rxIn.target == CONN_INST2 &&
    stateReg[0] == ST_NONEX |=> !evtReg.run && !evtReg.idle)
  else $error("poll acted on before allocation");

  a_poll_run: assert property (
    clkEn && rxIn.valid && rxIn.target == CONN_INST2 && rxIn.len != 4'h0 &&
    stateReg[0] != ST_NONEX && inst2Mode == MODE_POLL
    |=> evtReg.run && !evtReg.idle && txReg.valid)
  else $error("poll with data gave no run event");

  a_poll_wins: assert property (
    allocReg[ALLOC_POLL] && existVec[2] |-> inst2Mode == MODE_POLL)
  else $error("instance 2 left poll behaviour");

  a_unack: assert property (
    clkEn && rxIn.valid && rxIn.target == CONN_INST2 &&
    inst2Mode == MODE_COS_UNACK |=> !txReg.valid)
  else $error("unacknowledged instance 2 produced an answer");
endmodule

// ### fieldbus_io_pkg.sv
// Purpose: Shared constants and types for the slave I/O connection block
// Assumes: APB register bus, 32-bit data, one word per register
// Notes: Connection index 0 is instance 2, 1 is bit-strobe, 2 is instance 4
package fieldbus_io_pkg;
  localparam logic [31:0] REG_ALLOC = 32'h0000_0000;
  localparam logic [31:0] REG_RELEASE = 32'h0000_0004;
  localparam logic [31:0] REG_SEL = 32'h0000_0008;
  localparam logic [31:0] REG_CMD = 32'h0000_000c;
  localparam logic [31:0] REG_TRIG = 32'h0000_0010;
  localparam logic [31:0] REG_PSIZE = 32'h0000_0014;
  localparam logic [31:0] REG_CSIZE = 32'h0000_0018;
  localparam logic [31:0] REG_OUTID = 32'h0000_001c;
  localparam logic [31:0] REG_INID = 32'h0000_0020;
  localparam logic [31:0] REG_PROFILE = 32'h0000_0024;
  localparam logic [31:0] REG_STATE = 32'h0000_0028;
  localparam logic [31:0] REG_PATH = 32'h0000_002c;
  localparam int ALLOC_POLL = 1;
  localparam int ALLOC_STROBE = 2;
  localparam int ALLOC_COS = 4;
  localparam int ALLOC_CYC = 5;
  localparam int ALLOC_ACKSUP = 6;
  localparam int CMD_APPLY = 0;
  localparam int CMD_TMO = 4;
  localparam logic [1:0] CONN_INST2 = 2'h0;
  localparam logic [1:0] CONN_STROBE = 2'h1;
  localparam logic [1:0] CONN_INST4 = 2'h2;
  localparam logic [7:0] TRIG_CLASS0 = 8'h00;
  localparam logic [7:0] TRIG_CLASS2 = 8'h82;
  localparam logic [7:0] TRIG_CLASS3 = 8'h83;
  localparam logic [15:0] STROBE_MAX = 16'h0008;
  localparam logic [15:0] DEF_IO_SIZE = 16'h0008;
  localparam logic [15:0] ZERO_SIZE = 16'h0000;
  localparam logic [7:0] PROFILE_VAL = 8'h01;
  localparam logic [7:0] ACK_HANDLER_INST = 8'h01;
  localparam logic [7:0] ACK_HANDLER_CLASS = 8'h2b;
  localparam int DATA_W = 64;
  typedef enum logic [1:0] {
    ST_NONEX = 2'h0,
    ST_CONFIG = 2'h1,
    ST_ESTAB = 2'h3,
    ST_TIMEOUT = 2'h2
  } connState_t;
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_POLL = 2'h1,
    MODE_COS_ACK = 2'h3,
    MODE_COS_UNACK = 2'h2
  } inst2Mode_t;
  typedef struct packed {
    logic valid;
    logic [1:0] target;
    logic [3:0] len;
    logic [DATA_W-1:0] data;
  } rxFrame_t;
  typedef struct packed {
    logic valid;
    logic [1:0] conn;
    logic [15:0] len;
  } txReq_t;
  typedef struct packed {
    logic idle;
    logic run;
    logic trigger;
    logic strobeBit;
    logic ackSeen;
  } appEvt_t;
endpackage

// ### fieldbus_master_model.sv
// Purpose: Network master model handing decoded frames to the slave
// Assumes: Frames launched just after a rising edge, one cycle each
// Notes: Between frames the data lines show the inverse of the last one
module fieldbus_master_model (
  input wire logic clk,
  input wire fieldbus_io_pkg::txReq_t txOut,
  output fieldbus_io_pkg::rxFrame_t rxIn
);
  import fieldbus_io_pkg::*;
  int emptyResp = 0;
  int emptyPoll = 0;
  initial rxIn = '0;
  // One client send, 64-bit string for strobe, bit n for node n
  task automatic send(input logic [1:0] tgt, input logic [3:0] len,
    input logic [DATA_W-1:0] d);
    @(posedge clk);
    rxIn <= '{valid: 1'b1, target: tgt, len: len, data: d};
    @(posedge clk);
    rxIn <= '{valid: 1'b0, target: ~tgt, len: ~len, data: ~d};
  endtask
  // Empty strobe answer counts as no valid data
  always @(posedge clk)
    if (txOut.valid && txOut.len == ZERO_SIZE && txOut.conn == CONN_STROBE)
      emptyResp <= emptyResp + 1;
  // Empty instance 2 answer counts as no valid poll data
  always @(posedge clk)
    if (txOut.valid && txOut.len == ZERO_SIZE && txOut.conn == CONN_INST2)
      emptyPoll <= emptyPoll + 1;
endmodule

// ### fieldbus_slave_io_connections_tb_top.sv
// Purpose: Self-checking bench for the slave I/O connection block
// Assumes: APB master and frame source driven after rising edges
// Notes: Expected sizes kept in a small model array
module fieldbus_slave_io_connections_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fieldbus_io_pkg::*;
  logic clk = 1'b0;
  logic rstB = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd, sz;
  logic pready, pslverr, er;
  logic [5:0] nodeAddr = '0;
  rxFrame_t rxIn;
  txReq_t txOut;
  appEvt_t appEvt;
  logic [DATA_W-1:0] outData, d;
  logic [31:0] ro[3] = '{REG_OUTID, REG_INID, REG_PROFILE};
  int errCount = 0;
  int testsRun = 0;
  int seed = 84;
  int psz[3] = '{8, 8, 8};

  always #50 clk = ~clk;

  fieldbus_slave_io_connections u_dut (.clk(clk), .rst_b(rstB),
    .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .nodeAddrPin(nodeAddr), .rxIn(rxIn),
    .txOut(txOut), .appEvt(appEvt), .outData(outData));
  fieldbus_master_model u_master (.clk(clk), .txOut(txOut), .rxIn(rxIn));

  task automatic check(input string nm, input logic [63:0] seen,
    input logic [63:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [31:0] a, wd,
    input logic xe, input logic [31:0] xr, input string nm);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      errCount++;
      completeRun();
    end
    else
    begin
      check({nm, "Err"}, er, xe);
      if (!wr)
        check(nm, rd, xr);
    end
  endtask

  task automatic frame(input logic [1:0] t, input logic [3:0] len,
    input logic ac, input logic tx, input int txLen);
    d = {$random(seed), $random(seed)};
    u_master.send(t, len, d);
    @(negedge clk);
    check("ack", appEvt.ackSeen, ac && t == 2'h2);
    check("run", appEvt.run, ac && t != 2'h2 && len != 0);
    check("idle", appEvt.idle, ac && t != 2'h2 && len == 0);
    check("trig", appEvt.trigger, ac && t != 2'h2);
    check("txValid", txOut.valid, tx);
    if (tx)
      check("tx", {txOut.conn, txOut.len}, {t, 16'(txLen)});
    if (ac && t == CONN_STROBE && len != 0)
      check("bit", appEvt.strobeBit, d[nodeAddr]);
    if (ac && tx && t == CONN_INST2 && len != 0)
      check("out", outData, d);
  endtask

  initial
  begin
    nodeAddr = 6'($random(seed));
    repeat (20) @(posedge clk);
    rstB <= 1'b1;
    repeat (6) @(posedge clk);
    frame(2'h1, 4'h8, 0, 0, 0);
    frame(2'h0, 4'h8, 0, 0, 0);
    acc(0, REG_STATE, 0, 0, 0, "state");
    acc(0, 32'h0000_0040, 0, 1, 0, "unmapped");
    acc(1, REG_ALLOC, 32'h06, 0, 0, "alloc");
    acc(0, REG_STATE, 0, 0, 32'h45, "state");
    acc(1, REG_SEL, 32'h03, 0, 0, "sel");
    acc(0, REG_TRIG, 0, 1, 0, "selBad");
    acc(1, REG_SEL, 32'h01, 0, 0, "sel");
    acc(0, REG_TRIG, 0, 0, 32'h82, "trig");
    acc(0, REG_OUTID, 0, 0, {21'h0, 4'h5, 1'b0, nodeAddr}, "outId");
    acc(0, REG_INID, 0, 0, {21'h0, 2'h2, nodeAddr, 3'h5}, "inId");
    acc(0, REG_PATH, 0, 0, {16'h0, ACK_HANDLER_CLASS, ACK_HANDLER_INST},
      "path");
    for (logic [31:0] v = 32'h80; v < 32'h85; v++)
      acc(1, REG_TRIG, v, !(v == 32'h82 || v == 32'h83), 0, "trigWr");
    acc(0, REG_TRIG, 0, 0, 32'h83, "trig");
    sz = {$random(seed)} % 9;
    psz[1] = int'(sz);
    acc(1, REG_PSIZE, 32'h08, 0, 0, "psize");
    acc(1, REG_PSIZE, sz, 0, 0, "psize");
    acc(1, REG_PSIZE, 32'h09, 1, 0, "psize");
    acc(0, REG_PSIZE, 0, 0, sz, "psize");
    acc(1, REG_CSIZE, 32'h08, 0, 0, "csize");
    foreach (ro[i])
      acc(1, ro[i], 32'h0, 1, 0, "roWr");
    acc(0, REG_PROFILE, 0, 0, 32'h01, "profile");
    frame(2'h1, 4'h8, 1, 1, psz[1]);
    frame(2'h1, 4'h0, 1, 1, psz[1]);
    frame(2'h0, 4'h8, 1, 1, psz[0]);
    frame(2'h0, 4'h0, 1, 1, psz[0]);
    frame(2'h2, 4'h0, 0, 0, 0);
    acc(1, REG_CMD, 32'h02, 0, 0, "apply");
    acc(1, REG_TRIG, 32'h82, 1, 0, "trigEst");
    acc(0, REG_STATE, 0, 0, 32'h4d, "state");
    acc(1, REG_CMD, 32'h20, 0, 0, "timeout");
    acc(0, REG_STATE, 0, 0, 32'h49, "state");
    acc(1, REG_ALLOC, 32'h10, 0, 0, "alloc");
    acc(0, REG_STATE, 0, 0, 32'h59, "state");
    frame(2'h2, 4'h0, 1, 0, 0);
    acc(1, REG_SEL, 32'h00, 0, 0, "sel");
    acc(1, REG_PSIZE, 32'h00, 0, 0, "psize");
    psz[0] = 0;
    frame(2'h0, 4'h8, 1, 1, psz[0]);
    @(negedge clk);
    check("emptyPoll", u_master.emptyPoll, 1);
    acc(1, REG_RELEASE, 32'h76, 0, 0, "release");
    acc(0, REG_STATE, 0, 0, 0, "state");
    acc(1, REG_ALLOC, 32'h20, 0, 0, "alloc");
    acc(0, REG_STATE, 0, 0, 32'hd1, "state");
    frame(2'h0, 4'h8, 1, 1, 0);
    acc(1, REG_RELEASE, 32'h76, 0, 0, "release");
    acc(1, REG_ALLOC, 32'h50, 0, 0, "alloc");
    acc(0, REG_STATE, 0, 0, 32'h91, "state");
    acc(1, REG_SEL, 32'h00, 0, 0, "sel");
    acc(0, REG_TRIG, 0, 0, 32'h00, "trig");
    acc(1, REG_SEL, 32'h02, 0, 0, "sel");
    acc(0, REG_TRIG, 0, 0, 32'h00, "trig4");
    frame(2'h0, 4'h8, 1, 0, 0);
    frame(2'h2, 4'h0, 0, 0, 0);
    check("emptyStrobe", u_master.emptyResp, (sz == 0) ? 2 : 0);
    completeRun();
  end
endmodule
